/* shared/swdc_pkg.sv */
// Constants and types shared by the snooped write-back data cache
`default_nettype none
package swdc_pkg;
  localparam int SWDC_SETS = 128;
  localparam int SWDC_WAYS = 4;
  localparam int SWDC_BEATS = 4;
  localparam int SWDC_LINES = SWDC_SETS * SWDC_WAYS;
  localparam int SWDC_DWORDS = SWDC_LINES * SWDC_BEATS;
  localparam int SWDC_ADDR_W = 32;
  localparam int SWDC_DATA_W = 64;
  localparam int SWDC_BE_W = 8;
  localparam int SWDC_IDX_W = 7;
  localparam int SWDC_WAY_W = 2;
  localparam int SWDC_DW_W = 2;
  localparam int SWDC_TAG_W = 20;
  // Address field positions; the block offset is the low five bits
  localparam int SWDC_BLK_OFF_W = 5;
  localparam int SWDC_DW_LSB = 3;
  localparam int SWDC_IDX_LSB = 5;
  localparam int SWDC_TAG_LSB = 12;
  // Coherency state encodings
  localparam logic [1:0] SWDC_ST_INV = 2'h0;
  localparam logic [1:0] SWDC_ST_EXC = 2'h1;
  localparam logic [1:0] SWDC_ST_MOD = 2'h2;
  localparam logic [1:0] SWDC_RST_STATE = SWDC_ST_INV;
  localparam logic [1:0] SWDC_LAST_BEAT = 2'h3;
  localparam logic [7:0] SWDC_BE_ALL = 8'hff;
  typedef enum logic [1:0] {
    SWDC_IDLE,
    SWDC_FILL,
    SWDC_SINGLE
  } swdc_fsm_t;
endpackage
`default_nettype wire

/* rtl/swdc_cache.sv */
// Snooped four-way write-back data cache with burst fill and push engine
`timescale 1ns/1ns
`default_nettype none
module swdc_cache
  import swdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire logic reqFetch,
  input wire logic reqWrite,
  input wire logic [SWDC_ADDR_W-1:0] reqAddr,
  input wire logic [SWDC_DATA_W-1:0] reqWdata,
  input wire logic [SWDC_BE_W-1:0] reqBe,
  input wire logic reqWriteThru,
  input wire logic reqInhibit,
  input wire logic reqCoherent,
  output logic respDone,
  output logic respFetch,
  output logic [SWDC_DATA_W-1:0] respData,
  input wire logic snpValid,
  input wire logic snpWrite,
  input wire logic [SWDC_ADDR_W-1:0] snpAddr,
  output logic snpDone,
  output logic snpHit,
  output logic snpRetry,
  output logic baValid,
  output logic [SWDC_ADDR_W-1:0] baAddr,
  output logic baWrite,
  output logic baBurst,
  output logic baGlobal,
  input wire logic baAck,
  input wire logic bdValid,
  input wire logic [SWDC_DATA_W-1:0] bdData,
  output logic bdReady,
  output logic bwValid,
  output logic [SWDC_DATA_W-1:0] bwData,
  output logic [SWDC_BE_W-1:0] bwBe,
  output logic bwLast,
  input wire logic bwAck
);

  // Storage arrays
  logic [1:0] stateMem [0:SWDC_LINES-1];
  logic [SWDC_TAG_W-1:0] tagMem [0:SWDC_LINES-1];
  logic [SWDC_DATA_W-1:0] dataMem [0:SWDC_DWORDS-1];

  swdc_fsm_t fsm;
  swdc_fsm_t next_fsm;
  logic [SWDC_IDX_W-1:0] fillSet;
  logic [SWDC_WAY_W-1:0] fillWay;
  logic [SWDC_TAG_W-1:0] fillTag;
  logic [SWDC_DW_W-1:0] critDw;
  logic [SWDC_DW_W-1:0] fillCnt;
  logic [2:0] fillOff;
  logic fillRead;
  logic [SWDC_WAY_W-1:0] rrPtr;
  logic rdAddrPend;
  logic rdBurst;
  logic rdGbl;
  logic [SWDC_ADDR_W-1:0] rdAddr;
  logic pushBusy;
  logic pushAddrPend;
  logic pushBurst;
  logic pushGbl;
  logic [SWDC_ADDR_W-1:0] pushAddr;
  logic [SWDC_BE_W-1:0] pushBe;
  logic [SWDC_DW_W-1:0] pushIdx;
  logic [SWDC_DATA_W-1:0] pushBuf [0:SWDC_BEATS-1];

  // Address fields
  wire [SWDC_IDX_W-1:0] reqSet = reqAddr[SWDC_TAG_LSB-1:SWDC_IDX_LSB];
  wire [SWDC_TAG_W-1:0] reqTag = reqAddr[SWDC_ADDR_W-1:SWDC_TAG_LSB];
  wire [SWDC_DW_W-1:0] reqDw = reqAddr[SWDC_IDX_LSB-1:SWDC_DW_LSB];
  wire [SWDC_IDX_W-1:0] snpSet = snpAddr[SWDC_TAG_LSB-1:SWDC_IDX_LSB];
  wire [SWDC_TAG_W-1:0] snpTag = snpAddr[SWDC_ADDR_W-1:SWDC_TAG_LSB];

  // Single tag port: a snoop takes it whenever present
  wire lkSnoop = snpValid && !snpDone;
  wire [SWDC_IDX_W-1:0] lkSet = lkSnoop ? snpSet : reqSet;
  wire [SWDC_TAG_W-1:0] lkTag = lkSnoop ? snpTag : reqTag;

  logic [SWDC_WAYS-1:0] wayHit;
  logic [SWDC_WAYS-1:0] wayInv;
  logic [1:0] lkState [0:SWDC_WAYS-1];
  genvar w;
  generate
    for (w = 0; w < SWDC_WAYS; w++) begin : g_way
      localparam logic [SWDC_WAY_W-1:0] WAYN = SWDC_WAY_W'(w);
      assign lkState[w] = stateMem[{lkSet, WAYN}];
      assign wayInv[w] = (lkState[w] == SWDC_ST_INV);
      assign wayHit[w] = !wayInv[w] && (tagMem[{lkSet, WAYN}] == lkTag);
    end
  endgenerate

  logic [SWDC_WAY_W-1:0] hitWay;
  logic [SWDC_WAY_W-1:0] victimWay;
  always_comb begin
    hitWay = '0;
    victimWay = rrPtr;
    for (int i = SWDC_WAYS - 1; i >= 0; i--) begin
      if (wayHit[i]) begin
        hitWay = SWDC_WAY_W'(i);
      end
      if (wayInv[i]) begin
        victimWay = SWDC_WAY_W'(i);
      end
    end
  end

  wire hitAny = |wayHit;
  wire [1:0] hitState = lkState[hitWay];
  wire [1:0] victimState = lkState[victimWay];
  wire victimDirty = (victimState == SWDC_ST_MOD);

  // Fill beat handling
  wire [SWDC_DW_W-1:0] fillDw = critDw + fillCnt;
  wire bdAcc = bdValid && bdReady;
  wire fillAcc = (fsm == SWDC_FILL) && bdAcc;
  wire fillLast = fillAcc && (fillCnt == SWDC_LAST_BEAT);
  wire singleAcc = (fsm == SWDC_SINGLE) && bdAcc;
  wire tagWrite = fillLast;

  // Snoop arbitration; a clash with a tag write leaves it pending
  wire snpGo = lkSnoop && !tagWrite;
  wire snpHitM = hitAny && (hitState == SWDC_ST_MOD);
  // A modified hit needs the push buffer; if busy it rearbitrates later
  wire snpAct = snpGo && !(snpHitM && pushBusy);
  wire snpUpd = snpAct && hitAny && (snpWrite || snpHitM);
  wire [1:0] snpNewSt = snpWrite ? SWDC_ST_INV : SWDC_ST_EXC;

  // Core requests wait out any snoop, then run the next cycle
  wire coreGo = (fsm == SWDC_IDLE) && reqValid && !respDone && !lkSnoop;
  wire coreHit = hitAny && !reqInhibit;
  // A load or store miss to a block held in the push buffer is a dependency
  wire rdDepend = pushBusy && (pushAddr[SWDC_ADDR_W-1:SWDC_BLK_OFF_W]
                               == reqAddr[SWDC_ADDR_W-1:SWDC_BLK_OFF_W]);
  wire wantSingleWr = reqWrite && (reqInhibit || reqWriteThru);
  wire doRdHit = coreGo && !reqWrite && coreHit;
  wire doWrHit = coreGo && reqWrite && coreHit && !(reqWriteThru && pushBusy);
  wire doSingleWr = coreGo && wantSingleWr && !pushBusy;
  wire doFill = coreGo && !reqInhibit && !hitAny && !(reqWrite && reqWriteThru)
                && !(victimDirty && pushBusy) && !rdDepend;
  wire doRdSingle = coreGo && !reqWrite && reqInhibit && !pushBusy;

  // Push buffer capture: snoop push, dirty victim or queued single store
  wire pushLoad = (snpAct && snpHitM) || (doFill && victimDirty) || doSingleWr;
  wire [SWDC_IDX_W-1:0] capSet = snpAct ? snpSet : reqSet;
  wire [SWDC_WAY_W-1:0] capWay = snpAct ? hitWay : victimWay;
  wire [SWDC_ADDR_W-1:0] capBlk = {tagMem[{capSet, capWay}], capSet, 5'h00};
  wire [SWDC_ADDR_W-1:0] capAddr = doSingleWr ? reqAddr : capBlk;

  // Data array port: byte merge on store hits, beats on fills
  wire [SWDC_DATA_W-1:0] oldDw = dataMem[{reqSet, hitWay, reqDw}];
  logic [SWDC_DATA_W-1:0] mergeDw;
  genvar b;
  generate
    for (b = 0; b < SWDC_BE_W; b++) begin : g_byte
      assign mergeDw[b*8 +: 8] = reqBe[b] ? reqWdata[b*8 +: 8] : oldDw[b*8 +: 8];
    end
  endgenerate
  wire memWe = doWrHit || fillAcc;
  wire [SWDC_IDX_W+SWDC_WAY_W+SWDC_DW_W-1:0] memIdx =
    fillAcc ? {fillSet, fillWay, fillDw} : {reqSet, hitWay, reqDw};
  wire [SWDC_DATA_W-1:0] memWdata = fillAcc ? bdData : mergeDw;

  // State array port; sources never coincide
  wire stWe = snpUpd || (doWrHit && !reqWriteThru) || doFill || fillLast;
  wire [SWDC_IDX_W+SWDC_WAY_W-1:0] stIdx =
    snpUpd ? {snpSet, hitWay} :
    fillLast ? {fillSet, fillWay} :
    doFill ? {reqSet, victimWay} : {reqSet, hitWay};
  wire [1:0] stVal =
    snpUpd ? snpNewSt :
    fillLast ? SWDC_ST_EXC :
    doFill ? SWDC_ST_INV : SWDC_ST_MOD;

  // Byte select of the returned double word
  wire [SWDC_DATA_W-1:0] hitAligned = oldDw >> {reqAddr[2:0], 3'h0};
  wire [SWDC_DATA_W-1:0] beatAligned = bdData >> {fillOff, 3'h0};

  // Bus address arbitration: a read goes ahead of a queued push
  wire rdIssue = !baValid && rdAddrPend;
  wire pushIssue = !baValid && !rdAddrPend && pushAddrPend;
  wire pushAddrAck = baValid && baAck && baWrite;

  always_comb begin
    next_fsm = fsm;
    case (fsm)
      SWDC_IDLE: begin
        if (doFill) begin
          next_fsm = SWDC_FILL;
        end else if (doRdSingle) begin
          next_fsm = SWDC_SINGLE;
        end
      end
      SWDC_FILL: begin
        if (fillLast) begin
          next_fsm = SWDC_IDLE;
        end
      end
      SWDC_SINGLE: begin
        if (singleAcc) begin
          next_fsm = SWDC_IDLE;
        end
      end
      default: next_fsm = SWDC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fsm <= SWDC_IDLE;
      fillSet <= '0;
      fillWay <= '0;
      fillTag <= '0;
      critDw <= '0;
      fillCnt <= '0;
      fillOff <= '0;
      fillRead <= 1'b0;
      rrPtr <= '0;
    end else if (clkEn) begin
      fsm <= next_fsm;
      if (doFill || doRdSingle) begin
        fillSet <= reqSet;
        fillWay <= victimWay;
        fillTag <= reqTag;
        critDw <= reqDw;
        fillCnt <= '0;
        fillOff <= reqAddr[2:0];
        fillRead <= !reqWrite;
      end else if (fillAcc) begin
        fillCnt <= fillCnt + 2'h1;
      end
      if (doFill) begin
        rrPtr <= rrPtr + 2'h1;
      end
    end
  end

  // Critical beat goes to the unit at the same edge it lands in the array
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      respDone <= 1'b0;
      respFetch <= 1'b0;
      respData <= '0;
      bdReady <= 1'b0;
    end else if (clkEn) begin
      respDone <= doRdHit || doWrHit || doSingleWr;
      bdReady <= (next_fsm != SWDC_IDLE);
      if (doRdHit) begin
        respData <= hitAligned;
      end
      if ((fillAcc && fillCnt == 2'h0 && fillRead) || singleAcc) begin
        respDone <= 1'b1;
        respData <= beatAligned;
      end
      if (coreGo) begin
        respFetch <= reqFetch;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snpDone <= 1'b0;
      snpHit <= 1'b0;
      snpRetry <= 1'b0;
    end else if (clkEn) begin
      snpDone <= snpAct;
      snpHit <= snpAct && hitAny;
      snpRetry <= snpAct && snpHitM;
    end
  end

  // Address tenure; one read and one push at most in flight
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      baValid <= 1'b0;
      baAddr <= '0;
      baWrite <= 1'b0;
      baBurst <= 1'b0;
      baGlobal <= 1'b0;
      rdAddrPend <= 1'b0;
      rdAddr <= '0;
      rdBurst <= 1'b0;
      rdGbl <= 1'b0;
    end else if (clkEn) begin
      if (doFill || doRdSingle) begin
        rdAddrPend <= 1'b1;
        rdAddr <= doFill ? {reqAddr[SWDC_ADDR_W-1:SWDC_DW_LSB], 3'h0} : reqAddr;
        rdBurst <= doFill;
        rdGbl <= reqCoherent;
      end else if (rdIssue) begin
        rdAddrPend <= 1'b0;
      end
      if (baValid) begin
        if (baAck) begin
          baValid <= 1'b0;
        end
      end else if (rdAddrPend) begin
        baValid <= 1'b1;
        baAddr <= rdAddr;
        baWrite <= 1'b0;
        baBurst <= rdBurst;
        baGlobal <= rdGbl;
      end else if (pushAddrPend) begin
        baValid <= 1'b1;
        baAddr <= pushAddr;
        baWrite <= 1'b1;
        baBurst <= pushBurst;
        baGlobal <= pushGbl;
      end
    end
  end

  // Push engine: its data tenure runs regardless of the fill
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pushBusy <= 1'b0;
      pushAddrPend <= 1'b0;
      pushAddr <= '0;
      pushBurst <= 1'b0;
      pushGbl <= 1'b0;
      pushBe <= '0;
      pushIdx <= '0;
      bwValid <= 1'b0;
      bwData <= '0;
      bwBe <= '0;
      bwLast <= 1'b0;
    end else if (clkEn) begin
      if (pushLoad) begin
        pushBusy <= 1'b1;
        pushAddrPend <= 1'b1;
        pushAddr <= capAddr;
        pushBurst <= !doSingleWr;
        pushGbl <= doSingleWr && reqCoherent;
        pushBe <= doSingleWr ? reqBe : SWDC_BE_ALL;
      end else if (pushIssue) begin
        pushAddrPend <= 1'b0;
      end
      if (pushAddrAck) begin
        bwValid <= 1'b1;
        bwData <= pushBuf[0];
        bwBe <= pushBe;
        bwLast <= !pushBurst;
        pushIdx <= 2'h1;
      end else if (bwValid && bwAck) begin
        if (bwLast) begin
          bwValid <= 1'b0;
          bwLast <= 1'b0;
          pushBusy <= 1'b0;
        end else begin
          bwData <= pushBuf[pushIdx];
          bwLast <= (pushIdx == SWDC_LAST_BEAT);
          pushIdx <= pushIdx + 2'h1;
        end
      end
    end
  end

  // Buffer data needs no reset; it is only read after a load
  genvar p;
  generate
    for (p = 0; p < SWDC_BEATS; p++) begin : g_push
      localparam logic [SWDC_DW_W-1:0] BEATN = SWDC_DW_W'(p);
      always_ff @(posedge core_clk) begin
        if (clkEn && pushLoad) begin
          if (doSingleWr) begin
            pushBuf[p] <= (p == 0) ? reqWdata : '0;
          end else begin
            pushBuf[p] <= dataMem[{capSet, capWay, BEATN}];
          end
        end
      end
    end
  endgenerate

  // All blocks come out of reset invalid
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < SWDC_LINES; i++) begin
        stateMem[i] <= SWDC_RST_STATE;
      end
    end else if (clkEn && stWe) begin
      stateMem[stIdx] <= stVal;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clkEn && tagWrite) begin
      tagMem[{fillSet, fillWay}] <= fillTag;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clkEn && memWe) begin
      dataMem[memIdx] <= memWdata;
    end
  end

endmodule
`default_nettype wire

/* tb/swdc_cache_props.sv */
// Port assertions for the snooped data cache
`timescale 1ns/1ns
`default_nettype none
module swdc_cache_props
  import swdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reqWrite,
  input wire logic [31:0] reqAddr,
  input wire logic respDone,
  input wire logic [63:0] respData,
  input wire logic snpDone,
  input wire logic snpHit,
  input wire logic snpRetry,
  input wire logic baValid,
  input wire logic [31:0] baAddr,
  input wire logic baWrite,
  input wire logic baBurst,
  input wire logic baAck,
  input wire logic bdValid,
  input wire logic [63:0] bdData,
  input wire logic bdReady,
  input wire logic bwValid,
  input wire logic [7:0] bwBe,
  input wire logic bwLast,
  input wire logic bwAck
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Only the first beat of a read is forwarded
  logic firstBeat;
  wire logic [63:0] fwd = bdData >> {reqAddr[2:0], 3'h0};
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      firstBeat <= 1'b0;
    end else if (baValid && baAck && !baWrite) begin
      firstBeat <= 1'b1;
    end else if (bdValid && bdReady) begin
      firstBeat <= 1'b0;
    end
  end
  property p_rdAlign; baValid && !baWrite && baBurst |-> baAddr[2:0] == 3'h0; endproperty
  a_rdAlign: assert property (p_rdAlign) else $error("read burst misaligned");
  property p_pushAlign; baValid && baWrite && baBurst |-> baAddr[4:0] == 5'h0; endproperty
  a_pushAlign: assert property (p_pushAlign) else $error("push not block aligned");
  property p_baHold; baValid && !baAck |=> baValid && $stable(baAddr); endproperty
  a_baHold: assert property (p_baHold) else $error("address tenure dropped");
  property p_bwHold; bwValid && !bwAck |=> bwValid && $stable(bwBe) && $stable(bwLast); endproperty
  a_bwHold: assert property (p_bwHold) else $error("write beat dropped");
  property p_single; baValid && baAck && baWrite && !baBurst |=> bwValid && bwLast; endproperty
  a_single: assert property (p_single) else $error("single write not one beat");
  property p_burstWr;
    baValid && baAck && baWrite && baBurst |=> bwValid && !bwLast && bwBe == SWDC_BE_ALL;
  endproperty
  a_burstWr: assert property (p_burstWr) else $error("burst write start wrong");
  property p_crit;
    firstBeat && !reqWrite && bdValid && bdReady |=> respDone && respData == $past(fwd);
  endproperty
  a_crit: assert property (p_crit) else $error("critical word not forwarded");
  property p_retry; snpRetry |-> snpDone && snpHit; endproperty
  a_retry: assert property (p_retry) else $error("retry without hit");
  property p_rst; $fell(sys_rst) |-> !respDone && !snpDone && !baValid && !bwValid; endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
endmodule
`default_nettype wire

/* tb/swdc_bus_model.sv */
// Behavioural system bus and memory facing the data cache
`timescale 1ns/1ns
`default_nettype none
module swdc_bus_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic baValid,
  input wire logic [31:0] baAddr,
  input wire logic baWrite,
  input wire logic baBurst,
  input wire logic baGlobal,
  output logic baAck,
  output logic bdValid,
  output logic [63:0] bdData,
  input wire logic bdReady,
  input wire logic bwValid,
  input wire logic [63:0] bwData,
  input wire logic [7:0] bwBe,
  input wire logic bwLast,
  output logic bwAck
);
  // Slow mode answers only every other cycle
  logic tick, rBurst, wLast;
  logic [31:0] rAddr, wAddr;
  logic [2:0] left;
  logic [7:0] wBe;
  logic rGbl, wGbl;
  logic [63:0] wData;
  int nRd, nWr;
  wire logic go = !slow || tick;
  wire logic [31:0] dw = {rAddr[31:3], 3'h0};
  wire logic took = bdValid && bdReady;
  // Idle data shows the inverse, so a stale value never matches
  assign bdData = bdValid ? {~dw, dw} : {dw, ~dw};
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {tick, baAck, bwAck, bdValid, left, nRd, nWr} <= '0;
    end else begin
      tick <= ~tick;
      baAck <= baValid && !baAck && go;
      bwAck <= bwValid && !bwAck && go;
      bdValid <= go && left > {2'h0, took};
      if (took) begin
        left <= left - 3'h1;
        rAddr[4:3] <= rAddr[4:3] + 2'h1;
      end
      if (baValid && baAck && !baWrite) begin
        {rAddr, rBurst, nRd} <= {baAddr, baBurst, nRd + 1};
        rGbl <= baGlobal;
        left <= baBurst ? 3'h4 : 3'h1;
      end
      if (baValid && baAck && baWrite) begin
        wAddr <= baAddr;
        wGbl <= baGlobal;
      end
      if (bwValid && bwAck) begin
        {wBe, wLast, nWr} <= {bwBe, bwLast, nWr + 1};
        wData <= bwData;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the snooped data cache
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [31:0] blkA = 32'h1000_0000;
  logic core_clk, sys_rst, clkEn, slow, reqValid, reqFetch, reqWrite;
  logic reqWriteThru, reqInhibit, reqCoherent, respDone, respFetch;
  logic snpValid, snpWrite, snpDone, snpHit, snpRetry, baValid, baWrite;
  logic baBurst, baGlobal, baAck, bdValid, bdReady, bwValid, bwLast, bwAck;
  logic [31:0] reqAddr, snpAddr, baAddr;
  logic [63:0] reqWdata, respData, bdData, bwData, q;
  logic [7:0] reqBe, bwBe;
  logic hit, rty;
  int nErrors, totalChecks, lat;
  swdc_cache DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .reqValid(reqValid),
    .reqFetch(reqFetch), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .reqBe(reqBe), .reqWriteThru(reqWriteThru), .reqInhibit(reqInhibit),
    .reqCoherent(reqCoherent), .respDone(respDone), .respFetch(respFetch),
    .respData(respData), .snpValid(snpValid), .snpWrite(snpWrite), .snpAddr(snpAddr),
    .snpDone(snpDone), .snpHit(snpHit), .snpRetry(snpRetry), .baValid(baValid),
    .baAddr(baAddr), .baWrite(baWrite), .baBurst(baBurst), .baGlobal(baGlobal),
    .baAck(baAck), .bdValid(bdValid), .bdData(bdData), .bdReady(bdReady),
    .bwValid(bwValid), .bwData(bwData), .bwBe(bwBe), .bwLast(bwLast), .bwAck(bwAck)
  );
  swdc_bus_model bus (
    .core_clk(core_clk), .sys_rst(sys_rst), .slow(slow), .baValid(baValid),
    .baAddr(baAddr), .baWrite(baWrite), .baBurst(baBurst), .baGlobal(baGlobal),
    .baAck(baAck), .bdValid(bdValid), .bdData(bdData), .bdReady(bdReady),
    .bwValid(bwValid), .bwData(bwData), .bwBe(bwBe), .bwLast(bwLast), .bwAck(bwAck)
  );
  function automatic logic [63:0] mw(input logic [31:0] a);
    return {~{a[31:3], 3'h0}, a[31:3], 3'h0};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic waitFor(input int sel, input int n);
    lat = 0;
    while (!(sel == 0 ? respDone === 1'b1 : sel == 1 ? snpDone === 1'b1 : bus.nWr >= n)) begin
      @(negedge core_clk);
      lat++;
      if (lat > 300) begin
        nErrors++;
        tally_and_finish();
      end
    end
  endtask
  task automatic core(input logic [2:0] m, input logic [31:0] a, input logic [63:0] d,
      input logic [7:0] be);
    {reqInhibit, reqWriteThru, reqWrite} = m;
    {reqValid, reqAddr, reqWdata, reqBe} = {1'h1, a, d, be};
    waitFor(0, 0);
    q = respData;
    reqValid = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic snoop(input logic w, input logic [31:0] a);
    {snpValid, snpWrite, snpAddr} = {1'h1, w, a};
    waitFor(1, 0);
    {hit, rty} = {snpHit, snpRetry};
    snpValid = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_fill();
    core(3'h0, blkA + 32'h10, 64'h0, 8'h0);
    chk(q, mw(blkA + 32'h10));
    chk(bus.rBurst, 1'h1);
    chk(bus.rGbl, 1'h1);
    core(3'h0, blkA + 32'h8, 64'h0, 8'h0);
    chk(q, mw(blkA + 32'h8));
    reqFetch = 1'b1;
    core(3'h0, blkA + 32'h13, 64'h0, 8'h0);
    chk(lat, 1);
    chk(q, mw(blkA + 32'h10) >> 24);
    chk(respFetch, 1'h1);
    reqFetch = 1'b0;
    chk(bus.nRd, 1);
  endtask
  task automatic t_store();
    core(3'h1, blkA + 32'h8, 64'hab00, 8'h02);
    chk(lat, 1);
    core(3'h0, blkA + 32'h8, 64'h0, 8'h0);
    chk(q, (mw(blkA + 32'h8) & ~64'hff00) | 64'hab00);
    chk(bus.nWr, 0);
  endtask
  task automatic t_snoop();
    snoop(1'h0, blkA + 32'h18);
    chk({hit, rty}, 2'h3);
    waitFor(2, 4);
    chk(bus.wAddr, blkA);
    chk(bus.wLast, 1'h1);
    chk(bus.wData, mw(blkA + 32'h18));
    chk(bus.wGbl, 1'h0);
    snoop(1'h0, blkA);
    chk({hit, rty}, 2'h2);
    snoop(1'h1, blkA);
    chk({hit, rty}, 2'h2);
    core(3'h0, blkA + 32'h8, 64'h0, 8'h0);
    chk(bus.nRd, 2);
  endtask
  task automatic t_single();
    slow = 1'b1;
    core(3'h4, 32'h2000_0008, 64'h0, 8'h0);
    chk(q, mw(32'h2000_0008));
    chk(bus.rBurst, 1'h0);
    core(3'h3, 32'h2000_0000, 64'h1122_3344, 8'h0f);
    waitFor(2, 5);
    chk({bus.wBe, bus.wLast}, 9'h01f);
    chk(bus.wData, 64'h1122_3344);
    chk(bus.wGbl, 1'h1);
    slow = 1'b0;
  endtask
  task automatic t_collide();
    int ts;
    int tr;
    {reqWrite, reqWriteThru, reqInhibit, reqAddr} = {3'h0, blkA + 32'h8};
    {reqValid, snpValid, snpWrite, snpAddr} = {3'h6, blkA};
    {ts, tr} = '0;
    for (int i = 1; i < 20 && tr == 0; i++) begin
      @(negedge core_clk);
      if (snpDone === 1'b1) begin
        ts = i;
        snpValid = 1'b0;
      end
      if (respDone === 1'b1) begin
        tr = i;
        reqValid = 1'b0;
      end
    end
    chk(ts, 1);
    chk(tr, 2);
    @(negedge core_clk);
  endtask
  task automatic t_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    core(3'h0, blkA + 32'h8, 64'h0, 8'h0);
    chk(bus.nRd, 1);
    chk(q, mw(blkA + 32'h8));
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    {sys_rst, clkEn, reqCoherent} = 3'h7;
    {slow, reqValid, reqFetch, reqWrite, reqWriteThru, reqInhibit} = 6'h0;
    {snpValid, snpWrite, reqAddr, snpAddr, reqWdata, reqBe} = '0;
    {nErrors, totalChecks} = '0;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    t_fill();
    t_store();
    t_snoop();
    t_single();
    t_collide();
    t_reset();
    tally_and_finish();
  end
endmodule
bind swdc_cache swdc_cache_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .reqWrite(reqWrite), .reqAddr(reqAddr),
  .respDone(respDone), .respData(respData), .snpDone(snpDone), .snpHit(snpHit),
  .snpRetry(snpRetry), .baValid(baValid), .baAddr(baAddr), .baWrite(baWrite),
  .baBurst(baBurst), .baAck(baAck), .bdValid(bdValid), .bdData(bdData),
  .bdReady(bdReady), .bwValid(bwValid), .bwBe(bwBe), .bwLast(bwLast), .bwAck(bwAck)
);
`default_nettype wire
